// *** rtl/ukp_pkg.sv ***
package ukp_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned TRISTATE_US = 20;
  localparam int unsigned TRISTATE_CYC = TRISTATE_US * CLK_MHZ;
  localparam int unsigned PULSE_MS = 100;
  localparam int unsigned PULSE_CYC = PULSE_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 22;
  localparam int unsigned POR_W = 10;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int unsigned NPIN = 6;
  localparam int unsigned NEVT = 3;
  localparam logic [2:0] IDX_LIMIT = 3'(NPIN);

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EVENT = 8'h04;
  localparam logic [7:0] ADDR_PIN_CMD = 8'h08;
  localparam logic [7:0] ADDR_PIN_LEVEL = 8'h0c;
  localparam logic [7:0] ADDR_PIN_MODE = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_PEND = 8'h18;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int unsigned CTRL_CONFIGURED_BIT = 0;
  localparam int unsigned CTRL_SUSPENDED_BIT = 1;
  localparam int unsigned CTRL_REDUCED_BIT = 2;
  localparam int unsigned CTRL_PKG28_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'h4;
  localparam int unsigned EVT_TX_BIT = 0;
  localparam int unsigned EVT_RX_BIT = 1;
  localparam int unsigned EVT_PASS_BIT = 2;
  localparam int unsigned EVT_FAIL_BIT = 3;
  localparam int unsigned CMD_IDX_LSB = 0;
  localparam int unsigned CMD_MODE_LSB = 4;
  localparam int unsigned CMD_LEVEL_BIT = 8;
  localparam int unsigned STAT_REFUSED_BIT = 0;
  localparam logic [5:0] DOUT_RST = 6'h00;
  localparam logic [2:0] SLOT_VIRT_PIN_0 = 3'h0;
  localparam logic [2:0] SLOT_VIRT_PIN_1 = 3'h1;
  localparam logic [2:0] SLOT_VIRT_PIN_9 = 3'h4;
  localparam logic [2:0] SLOT_VIRT_PIN_10 = 3'h5;

  typedef enum logic [1:0] {MODE_DIN, MODE_DOUT, MODE_INT, MODE_AIN} ukp_mode_e;

endpackage

// *** rtl/ukp_evt_if.sv ***
`timescale 1ns/1ps
interface ukp_evt_if;
  logic [ukp_pkg::NEVT-1:0] trig;
  logic [ukp_pkg::NEVT-1:0] ind;
  modport src (output trig, input ind);
  modport stretch (input trig, output ind);
endinterface

// *** rtl/ukp_sync3.sv ***
`timescale 1ns/1ps
module ukp_sync3 #(
  parameter int unsigned W = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ------------------------------------------------------------
  // Three stages; a change is taken once stages two and three agree
  // ------------------------------------------------------------
  generate
    for (genvar g = 0; g < W; g++) begin : g_bit
      logic s1_r, s2_r, s3_r, q_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          q_r <= 1'b0;
        end else begin
          s1_r <= d[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            q_r <= s3_r;
          end
        end
      end
      assign q[g] = q_r;
    end
  endgenerate
endmodule // ukp_sync3

// *** rtl/ukp_stretch.sv ***
`timescale 1ns/1ps
module ukp_stretch #(
  parameter int unsigned PULSE_CYC_P = ukp_pkg::PULSE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  ukp_evt_if.stretch evt
);
  import ukp_pkg::*;

  // ------------------------------------------------------------
  // One retriggerable pulse counter per indicator
  // ------------------------------------------------------------
  generate
    for (genvar g = 0; g < NEVT; g++) begin : g_ch
      logic [CNT_W-1:0] cnt_r;
      logic ind_r;
      logic [CNT_W:0] since_r;
      // A new transfer reloads the full period, so steady traffic keeps the lamp lit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_r <= '0;
          ind_r <= 1'b0;
        end else if (evt.trig[g]) begin
          cnt_r <= CNT_W'(PULSE_CYC_P - 1);
          ind_r <= 1'b1;
        end else if (cnt_r != '0) begin
          cnt_r <= cnt_r - 1'b1;
        end else begin
          ind_r <= 1'b0;
        end
      end
      assign evt.ind[g] = ind_r;

      // Helper: cycles since the last trigger, saturating
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          since_r <= {1'b1, {CNT_W{1'b0}}};
        end else if (evt.trig[g]) begin
          since_r <= '0;
        end else if (!since_r[CNT_W]) begin
          since_r <= since_r + 1'b1;
        end
      end

      AST_PULSE_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        (!since_r[CNT_W]) |-> (ind_r == ((CNT_W+1)'(since_r) < (CNT_W+1)'(PULSE_CYC_P))))
        else $error("indicator pulse length wrong");
      AST_PULSE_RETRIG: assert property (@(posedge pclk) disable iff (!presetn)
        evt.trig[g] |=> ind_r [*4])
        else $error("indicator not held after trigger");
    end
  endgenerate
endmodule // ukp_stretch

// *** rtl/ukp_vio_top.sv ***
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
// What this block does
// - Outputs stay undriven about 20us after reset
// - Reset input is active low
// - Configured indicator low only when configured, awake
// - Reduced-current indicator high when limited to 100mA
// - Transmit indicator high 100ms per send
// - Receive indicator high 100ms per receive
// - Link indicator high 100ms after any transfer
// - Verify output follows last exchange result
// - Pin function chosen by pin configuration command
// - All virtual pins start as digital inputs
// - Digital input everywhere; level readable by query
// - Digital output sets level, starts inactive, not pin 0
// - Interrupt pin reports level, one response per cycle in which a pin rises
// - Interrupt mode only on pins 9 and 10
// - Analog only pin 1 (28-pin) or 10 (20-pin)
module ukp_vio_top #(
  parameter int unsigned PULSE_CYC_P = ukp_pkg::PULSE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ukp_pkg::NPIN-1:0] virt_pin_i,
  output logic [ukp_pkg::NPIN-1:0] virt_pin_o,
  output logic [ukp_pkg::NPIN-1:0] virt_pin_oe,
  output logic host_configured_ind_n,
  output logic reduced_current_ind,
  output logic transmit_activity_ind,
  output logic receive_activity_ind,
  output logic link_activity_ind,
  output logic verify_pass_ind,
  output logic ind_oe,
  output logic intr_resp_req
);
  import ukp_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic setup;
  logic wr_acc;
  logic [3:0] ctrl_r;
  logic [POR_W-1:0] por_cnt_r;
  logic drive_en_r;
  logic cfg_ind_n_r;
  logic reduced_r;
  logic auth_r;
  logic refused_r;
  logic [NPIN-1:0] irq_pend_r;
  logic [NPIN-1:0] dout_r;
  logic [NPIN-1:0] lvl;
  logic [NPIN-1:0] lvl_q_r;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] pin_level;
  logic [2*NPIN-1:0] mode_flat;
  logic intr_r;
  logic [31:0] prdata_r;
  logic slverr_r;
  ukp_mode_e mode_r [NPIN];
  logic evt_wr;
  logic tx_trig;
  logic rx_trig;
  logic cmd_wr;
  logic cmd_ok;
  logic [2:0] cmd_idx;
  ukp_mode_e cmd_mode;
  logic cmd_lvl;
  logic stat_clr;
  logic pend_wr;

  ukp_evt_if evt ();

  // ------------------------------------------------------------
  // Command legality per pin slot
  // ------------------------------------------------------------
  function automatic logic mode_ok(input logic [2:0] idx, input ukp_mode_e m,
                                   input logic pkg28);
    logic ok;
    ok = 1'b0;
    case (m)
      MODE_DIN: ok = 1'b1;
      MODE_DOUT: ok = (idx != SLOT_VIRT_PIN_0);
      MODE_INT: ok = (idx == SLOT_VIRT_PIN_9) || (idx == SLOT_VIRT_PIN_10);
      MODE_AIN: ok = pkg28 ? (idx == SLOT_VIRT_PIN_1) : (idx == SLOT_VIRT_PIN_10);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign pready = psel & penable;
  assign prdata = prdata_r;
  assign pslverr = slverr_r;

  assign evt_wr = wr_acc & (paddr == ADDR_EVENT);
  assign tx_trig = evt_wr & pwdata[EVT_TX_BIT];
  assign rx_trig = evt_wr & pwdata[EVT_RX_BIT];
  assign cmd_wr = wr_acc & (paddr == ADDR_PIN_CMD);
  assign cmd_idx = pwdata[CMD_IDX_LSB +: 3];
  assign cmd_mode = ukp_mode_e'(pwdata[CMD_MODE_LSB +: 2]);
  assign cmd_lvl = pwdata[CMD_LEVEL_BIT];
  assign cmd_ok = cmd_wr & (cmd_idx < IDX_LIMIT) &
                  mode_ok(cmd_idx, cmd_mode, ctrl_r[CTRL_PKG28_BIT]);
  assign stat_clr = wr_acc & (paddr == ADDR_STATUS) & pwdata[STAT_REFUSED_BIT];
  assign pend_wr = wr_acc & (paddr == ADDR_IRQ_PEND);

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_acc && paddr == ADDR_CTRL) begin
      ctrl_r <= pwdata[3:0];
    end
  end

  // ------------------------------------------------------------
  // Power-on output hold-off
  // ------------------------------------------------------------
  // Outputs float until the counter expires so straps and pull-ups settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_cnt_r <= '0;
      drive_en_r <= 1'b0;
    end else if (!drive_en_r) begin
      por_cnt_r <= por_cnt_r + 1'b1;
      if (por_cnt_r == POR_W'(TRISTATE_CYC - 1)) begin
        drive_en_r <= 1'b1;
      end
    end
  end
  assign ind_oe = drive_en_r;

  // ------------------------------------------------------------
  // Status indicators
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ind_n_r <= 1'b1;
      reduced_r <= 1'b1;
    end else begin
      cfg_ind_n_r <= ~(ctrl_r[CTRL_CONFIGURED_BIT] & ~ctrl_r[CTRL_SUSPENDED_BIT]);
      reduced_r <= ctrl_r[CTRL_REDUCED_BIT];
    end
  end
  assign host_configured_ind_n = cfg_ind_n_r;
  assign reduced_current_ind = reduced_r;

  // A failed exchange wins if both results are posted at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auth_r <= 1'b0;
    end else if (evt_wr && pwdata[EVT_FAIL_BIT]) begin
      auth_r <= 1'b0;
    end else if (evt_wr && pwdata[EVT_PASS_BIT]) begin
      auth_r <= 1'b1;
    end
  end
  assign verify_pass_ind = auth_r;

  // ------------------------------------------------------------
  // Activity pulse stretchers
  // ------------------------------------------------------------
  assign evt.trig = {tx_trig | rx_trig, rx_trig, tx_trig};
  ukp_stretch #(.PULSE_CYC_P(PULSE_CYC_P)) u_stretch (
    .pclk(pclk),
    .presetn(presetn),
    .evt(evt)
  );
  assign transmit_activity_ind = evt.ind[0];
  assign receive_activity_ind = evt.ind[1];
  assign link_activity_ind = evt.ind[2];

  // ------------------------------------------------------------
  // Virtual pin configuration
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NPIN; i++) begin
        mode_r[i] <= MODE_DIN;
      end
      dout_r <= DOUT_RST;
    end else if (cmd_ok) begin
      mode_r[cmd_idx] <= cmd_mode;
      if (cmd_mode == MODE_DOUT) begin
        dout_r[cmd_idx] <= cmd_lvl;
      end
    end
  end

  // Refused commands leave the pin untouched; a new refusal beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_r <= 1'b0;
    end else begin
      refused_r <= (cmd_wr & ~cmd_ok) | (refused_r & ~stat_clr);
    end
  end

  // ------------------------------------------------------------
  // Pin inputs, edges, readback
  // ------------------------------------------------------------
  ukp_sync3 #(.W(NPIN)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(virt_pin_i),
    .q(lvl)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q_r <= '0;
    end else begin
      lvl_q_r <= lvl;
    end
  end

  generate
    for (genvar g = 0; g < NPIN; g++) begin : g_pin
      // Analog pins have no digital path; conversion lives elsewhere
      assign pin_level[g] = (mode_r[g] == MODE_DOUT) ? dout_r[g] :
                            (mode_r[g] == MODE_AIN) ? 1'b0 : lvl[g];
      assign rise[g] = (mode_r[g] == MODE_INT) & lvl[g] & ~lvl_q_r[g];
      assign virt_pin_oe[g] = drive_en_r & (mode_r[g] == MODE_DOUT);
      assign virt_pin_o[g] = dout_r[g];
      assign mode_flat[2*g +: 2] = mode_r[g];
    end
  endgenerate

  // One response request per cycle with any rise; pending bits clear on write-one, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pend_r <= '0;
      intr_r <= 1'b0;
    end else begin
      irq_pend_r <= rise | (irq_pend_r & ~({NPIN{pend_wr}} & pwdata[NPIN-1:0]));
      intr_r <= |rise;
    end
  end
  assign intr_resp_req = intr_r;

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      slverr_r <= 1'b0;
    end else if (setup) begin
      slverr_r <= 1'b0;
      case (paddr)
        ADDR_CTRL: prdata_r <= 32'(ctrl_r);
        ADDR_EVENT: prdata_r <= '0;
        ADDR_PIN_CMD: prdata_r <= '0;
        ADDR_PIN_LEVEL: prdata_r <= 32'(pin_level);
        ADDR_PIN_MODE: prdata_r <= 32'(mode_flat);
        ADDR_STATUS: prdata_r <= 32'({auth_r, drive_en_r, refused_r});
        ADDR_IRQ_PEND: prdata_r <= 32'(irq_pend_r);
        default: begin
          prdata_r <= '0;
          slverr_r <= 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_cmd_write(logic [2:0] idx, ukp_mode_e m);
    cmd_wr && cmd_idx == idx && cmd_mode == m;
  endsequence

  sequence s_int_rise(int unsigned k);
    mode_r[k] == MODE_INT && $rose(lvl[k]);
  endsequence

  AST_TRISTATE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (por_cnt_r < POR_W'(TRISTATE_CYC - 1)) |-> (!ind_oe && virt_pin_oe == '0))
    else $error("outputs driven before hold-off");
  AST_TRISTATE_END: assert property (@(posedge pclk) disable iff (!presetn)
    (por_cnt_r == POR_W'(TRISTATE_CYC - 1)) |=> ind_oe [*8])
    else $error("outputs not enabled after hold-off");
  AST_CFG_IND: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r[CTRL_CONFIGURED_BIT] && !ctrl_r[CTRL_SUSPENDED_BIT]) [*2] |-> !host_configured_ind_n)
    else $error("configured indicator not low");
  AST_CFG_IND_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ctrl_r[CTRL_SUSPENDED_BIT]) |=> host_configured_ind_n)
    else $error("configured indicator low while suspended");
  AST_REDUCED: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(ctrl_r[CTRL_REDUCED_BIT]) |=> reduced_current_ind == $past(ctrl_r[CTRL_REDUCED_BIT]))
    else $error("reduced-current indicator wrong");
  AST_AUTH: assert property (@(posedge pclk) disable iff (!presetn)
    (evt_wr && pwdata[EVT_PASS_BIT] && !pwdata[EVT_FAIL_BIT]) |=> verify_pass_ind)
    else $error("verify output not set on pass");
  AST_AUTH_FAIL: assert property (@(posedge pclk) disable iff (!presetn)
    (evt_wr && pwdata[EVT_FAIL_BIT]) |=> !verify_pass_ind)
    else $error("verify output not cleared on fail");
  AST_NO_OUT_PIN0: assert property (@(posedge pclk) disable iff (!presetn)
    s_cmd_write(SLOT_VIRT_PIN_0, MODE_DOUT) |=> (mode_r[0] != MODE_DOUT && refused_r && !virt_pin_oe[0]))
    else $error("output mode taken on pin 0");
  AST_INT_SLOTS: assert property (@(posedge pclk) disable iff (!presetn)
    mode_r[0] != MODE_INT && mode_r[1] != MODE_INT && mode_r[2] != MODE_INT
    && mode_r[3] != MODE_INT)
    else $error("interrupt mode on wrong pin");
  AST_DOUT_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_ok && cmd_mode == MODE_DOUT) |=> (pin_level[$past(cmd_idx)] == $past(cmd_lvl)))
    else $error("output level not reported");
  AST_INT_EDGE9: assert property (@(posedge pclk) disable iff (!presetn)
    s_int_rise(4) |=> (intr_resp_req && irq_pend_r[4]))
    else $error("no response on pin 9 rise");
  AST_INT_EDGE10: assert property (@(posedge pclk) disable iff (!presetn)
    s_int_rise(5) |=> (intr_resp_req && irq_pend_r[5]))
    else $error("no response on pin 10 rise");
  // Only slots 4 and 5 can take interrupt mode, so two steady-high pins give no edge
  AST_INT_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
    (lvl[4] && $past(lvl[4]) && lvl[5] && $past(lvl[5])) |=> !intr_resp_req)
    else $error("response repeated for one rise");
  // A refused analog request must leave every pin mode as it was
  AST_ANALOG: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_wr && cmd_mode == MODE_AIN && cmd_idx != (ctrl_r[CTRL_PKG28_BIT] ?
      SLOT_VIRT_PIN_1 : SLOT_VIRT_PIN_10)) |=> (refused_r && $stable(mode_flat)))
    else $error("analog mode on wrong pin");

endmodule // ukp_vio_top

// *** tb/ukp_host_model.sv ***
`timescale 1ns/1ps
module ukp_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] rdata;
  logic rerr;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // ------------------------------------------------------------
  // One transfer, held until pready; only the bench watchdog ends a hung wait
  // ------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data lines must not keep a stale value
    pwdata <= ~d;
  endtask
endmodule // ukp_host_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import ukp_pkg::*;
  localparam int unsigned PW = 50;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [NPIN-1:0] vin = '0;
  logic [NPIN-1:0] vout, voe;
  logic hc_n, red, tx, rx, lk, ver, ioe, irq;
  int fail_count = 0;
  int checks_done = 0;
  int n;
  wire logic [2:0] act = {lk, rx, tx};
  wire logic [19:0] snap = {ioe, hc_n, red, tx, rx, lk, ver, voe, vout, irq};
  // Rows: control value, configured indicator, low power indicator
  logic [5:0] ctab [5] = '{6'h02, 6'h04, 6'h0e, 6'h15, 6'h13};
  // Rows: event bits, verify output
  logic [4:0] vtab [4] = '{5'h09, 5'h10, 5'h09, 5'h18};
  logic [8:0] pcmd [7] = '{9'h010, 9'h021, 9'h036, 9'h035, 9'h031, 9'h024, 9'h112};
  logic pref [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  always #12.5 pclk = ~pclk;

  ukp_vio_top #(.PULSE_CYC_P(PW)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .virt_pin_i(vin), .virt_pin_o(vout),
    .virt_pin_oe(voe), .host_configured_ind_n(hc_n), .reduced_current_ind(red),
    .transmit_activity_ind(tx), .receive_activity_ind(rx), .link_activity_ind(lk),
    .verify_pass_ind(ver), .ind_oe(ioe), .intr_resp_req(irq));

  ukp_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    i_host.xfer(1'b0, a, 32'h0);
    chk(nm, i_host.rdata, e);
  endtask

  // Counts edges until the chosen indicator drops
  task automatic meas(input int w);
    n = 0;
    do begin
      @(posedge pclk);
      #1 n++;
    end while (act[w] === 1'b1 && n < 200);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    #1 chk("reset outputs", 32'(snap), 32'h60000);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (TRISTATE_CYC - 5) @(posedge pclk);
    #1 chk("ind_oe early", 32'(ioe), 32'h0);
    repeat (10) @(posedge pclk);
    #1 chk("ind_oe late", 32'(ioe), 32'h1);
    foreach (ctab[i]) begin
      wr(ADDR_CTRL, 32'(ctab[i][5:2]));
      repeat (2) @(posedge pclk);
      #1 chk("cfg ind", 32'(hc_n), 32'(ctab[i][1]));
      chk("low pwr ind", 32'(red), 32'(ctab[i][0]));
    end
    i_host.xfer(1'b0, 8'h1c, 32'h0);
    chk("unmapped err", {i_host.rerr, i_host.rdata[30:0]}, 32'h80000000);
    wr(ADDR_EVENT, 32'h1);
    meas(0);
    chk("tx len", 32'(n), PW);
    wr(ADDR_EVENT, 32'h2);
    meas(1);
    chk("rx len", 32'(n), PW);
    wr(ADDR_EVENT, 32'h2);
    meas(2);
    chk("link len", 32'(n), PW);
    wr(ADDR_EVENT, 32'h1);
    repeat (20) @(posedge pclk);
    wr(ADDR_EVENT, 32'h1);
    meas(2);
    chk("retrig len", 32'(n), PW);
    foreach (vtab[i]) begin
      wr(ADDR_EVENT, 32'(vtab[i][4:1]));
      repeat (2) @(posedge pclk);
      #1 chk("verify", 32'(ver), 32'(vtab[i][0]));
    end
    wr(ADDR_CTRL, 32'h8);
    vin <= 6'h28;
    foreach (pcmd[i]) begin
      wr(ADDR_PIN_CMD, 32'(pcmd[i]));
      rd("refused", ADDR_STATUS, 32'({2'b01, pref[i]}));
      wr(ADDR_STATUS, 32'h1);
    end
    rd("modes", ADDR_PIN_MODE, 32'h21c);
    rd("levels", ADDR_PIN_LEVEL, 32'h2c);
    chk("pin drive", 32'({voe, vout}), 32'h104);
    // Clean single edge, as a debounced switch would give
    vin <= 6'h38;
    n = 0;
    repeat (15) begin
      @(posedge pclk);
      #1 n += int'(irq === 1'b1);
    end
    chk("irq pulses", 32'(n), 32'h1);
    rd("irq pend", ADDR_IRQ_PEND, 32'h10);
    wr(ADDR_IRQ_PEND, 32'h10);
    rd("irq clr", ADDR_IRQ_PEND, 32'h0);
    rd("int level", ADDR_PIN_LEVEL, 32'h3c);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1 chk("reset outputs", 32'(snap), 32'h60000);
    @(posedge pclk);
    presetn <= 1'b1;
    rd("modes reset", ADDR_PIN_MODE, 32'h0);
    repeat (4) @(posedge pclk);
    rd("levels reset", ADDR_PIN_LEVEL, 32'h38);
    conclude();
  end

  initial begin
    #(25 * 20000);
    fail_count++;
    conclude();
  end
endmodule // tb_top
